// File: inc/uart_map.vh
// Register map, field positions and rate constants for the nine-bit serial ports
`ifndef UART_MAP_VH
`define UART_MAP_VH

// Register addresses
`define UART_CTRL0_ADDR 8'h98
`define UART_BUF0_ADDR 8'h99
`define UART_CTRL1_ADDR 8'hc0
`define UART_BUF1_ADDR 8'hc1
`define UART_AUX_ADDR 8'h87

// Control register fields
`define UART_MODE_HI 7
`define UART_MODE_LO 6
`define UART_MP 5
`define UART_RXEN 4
`define UART_TX9 3
`define UART_RX9 2
`define UART_TXDONE 1
`define UART_RXDONE 0

// Auxiliary register fields
`define UART_DBL0 7
`define UART_DBL1 6
`define UART_T2SEL 5
`define UART_AUX_MASK 8'he0

// Reset values
`define UART_CTRL_RST 8'h00
`define UART_AUX_RST 8'h00
`define UART_BUF_RST 8'h00

// Fixed-rate prescaler reloads: sample tick at clk/4 or clk/2
`define UART_PRE_SLOW 2'h3
`define UART_PRE_FAST 2'h1

// Frame and sampling positions
`define UART_SMP_LAST 4'hf
`define UART_VOTE_A 4'h7
`define UART_VOTE_C 4'h9
`define UART_STOP_IDX 4'ha
`define UART_NINTH_IDX 4'h9
`define UART_IDLE_PIN 1'b1

`endif

// File: rtl/pair_buffer.v
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module pair_buffer #(
	parameter WIDTH = 9
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

reg [WIDTH-1:0] mem_r [0:1];
reg wp_r;
reg rp_r;
reg [1:0] cnt_r;
wire push;
wire pop;

assign o_in_ready = (cnt_r != 2'h2);
assign o_out_valid = (cnt_r != 2'h0);
assign o_out_data = mem_r[rp_r];
assign push = i_in_valid && o_in_ready;
assign pop = o_out_valid && i_out_ready;

always @(posedge i_clk) begin
	if (i_rst) begin
		wp_r <= 1'b0;
		rp_r <= 1'b0;
		cnt_r <= 2'h0;
		mem_r[0] <= {WIDTH{1'b0}};
		mem_r[1] <= {WIDTH{1'b0}};
	end else begin
		if (push) begin
			mem_r[wp_r] <= i_in_data;
			wp_r <= ~wp_r;
		end
		if (pop) begin
			rp_r <= ~rp_r;
		end
		if (push && !pop) begin
			cnt_r <= cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_r <= cnt_r - 2'h1;
		end
	end
end

endmodule

// File: rtl/nine_bit_uart_multiproc.v
// Two nine-bit asynchronous serial ports with multiprocessor filtering
`timescale 1ns/1ps
`include "uart_map.vh"
// What this block does
// R01: Frame is start, eight data bits LSB first, ninth bit, stop: eleven bits.
// R02: Transmitted ninth bit comes from the software-written transmit ninth-bit field.
// R03: Fixed-rate mode runs at clk/64, or clk/32 with baud doubling.
// R04: Transmission starts on the first divide-by-16 rollover after a buffer write.
// R05: Output order is start, data LSB first, ninth bit, stop.
// R06: Transmit-done flag sets when the stop bit is placed on the pin.
// R07: Reception starts only on a start falling edge while receive is enabled.
// R08: Receiver samples the input sixteen times per bit at any rate.
// R09: Start edge resets the receive divide-by-16 counter to align bit boundaries.
// R10: Each bit value is a two-of-three vote on mid-bit samples.
// R11: Start bit not voted low abandons the frame and rearms edge search.
// R12: At mid stop accept only if receive-done clear and, multiprocessor, stop high.
// R13: Accepted frame loads buffer, receive ninth-bit field, sets receive-done.
// R14: Rejected frame leaves buffer, ninth-bit field and receive-done unchanged.
// R15: After mid stop the receiver watches for the next falling edge.
// R16: Timer-rate mode keeps the frame but takes rate from timer overflow.
// R17: With multiprocessor mode, receive event raised only when ninth bit is one.
// R18: A sending master marks address bytes with ninth bit one, data zero.
// R19: Addressed slave clears multiprocessor enable; others keep it set.
// R20: Timer overflow pulses divided by 16; timer 1 rate optionally halved.
// R21: Only port 0 may use timer 2, counting at clk/2.
// R22: Two independent port instances with own buffer, flags, enables, doubling.
module nine_bit_uart_multiproc #(
	parameter PORTS = 2
) (
	input wire i_clk,
	input wire i_rst,
	input wire [7:0] i_sfr_addr,
	input wire i_sfr_wr,
	input wire i_sfr_rd,
	input wire [7:0] i_sfr_wdata,
	output wire [7:0] o_sfr_rdata,
	input wire i_t1_ovf,
	input wire i_t2_ovf,
	output wire o_t2_inc,
	input wire [PORTS-1:0] i_serial_in_pin,
	output wire [PORTS-1:0] o_serial_out_pin,
	output wire [PORTS-1:0] o_tx_ready,
	output wire [PORTS-1:0] o_tx_done_flag,
	output wire [PORTS-1:0] o_rx_done_flag,
	output wire [PORTS-1:0] o_serial_irq
);

////////////////////////////////////////////////////////////////////////////////
// Address decode and majority vote helpers

function [7:0] ctrl_addr;
	input integer p;
	begin
		ctrl_addr = (p == 0) ? `UART_CTRL0_ADDR : `UART_CTRL1_ADDR;
	end
endfunction

function [7:0] buf_addr;
	input integer p;
	begin
		buf_addr = (p == 0) ? `UART_BUF0_ADDR : `UART_BUF1_ADDR;
	end
endfunction

function maj3;
	input a;
	input b;
	input c;
	begin
		maj3 = (a & b) | (a & c) | (b & c);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Shared auxiliary register and timer 2 increment strobe

reg [7:0] aux_r;
reg [7:0] rdata_r;
reg t2_div_r;
wire [8*PORTS-1:0] port_rd;
reg [7:0] rd_nxt;
integer k;

always @(posedge i_clk) begin
	if (i_rst) begin
		aux_r <= `UART_AUX_RST;
	end else if (i_sfr_wr && i_sfr_addr == `UART_AUX_ADDR) begin
		aux_r <= i_sfr_wdata & `UART_AUX_MASK;
	end
end

// Timer 2 counts at clk/2 while it is the baud source of port 0
always @(posedge i_clk) begin
	if (i_rst) begin
		t2_div_r <= 1'b0;
	end else begin
		t2_div_r <= aux_r[`UART_T2SEL] ? ~t2_div_r : 1'b0; // R21
	end
end
assign o_t2_inc = t2_div_r;

always @* begin
	rd_nxt = (i_sfr_addr == `UART_AUX_ADDR) ? aux_r : 8'h00;
	for (k = 0; k < PORTS; k = k + 1) begin
		rd_nxt = rd_nxt | port_rd[8*k +: 8];
	end
end

always @(posedge i_clk) begin
	if (i_rst) begin
		rdata_r <= 8'h00;
	end else if (i_sfr_rd) begin
		rdata_r <= rd_nxt;
	end
end
assign o_sfr_rdata = rdata_r;

////////////////////////////////////////////////////////////////////////////////
// Serial ports

genvar g;
generate
	for (g = 0; g < PORTS; g = g + 1) begin : port // R22
		reg [7:0] ctrl_r;
		reg [7:0] ctrl_nxt;
		reg [7:0] rbuf_r;
		reg [1:0] pre_r;
		reg half_r;
		reg tick_r;
		reg [3:0] txc_r;
		reg tx_busy_r;
		reg [3:0] txi_r;
		reg [10:0] txs_r;
		reg txo_r;
		reg rs1_r;
		reg rs2_r;
		reg rprev_r;
		reg rx_busy_r;
		reg [3:0] rxc_r;
		reg [3:0] rxi_r;
		reg [1:0] smp_r;
		reg [8:0] rsh_r;
		reg [7:0] rd_port;
		wire hit_ctrl;
		wire hit_buf;
		wire wr_ctrl;
		wire wr_buf;
		wire active;
		wire dbl;
		wire use_t2;
		wire ovf;
		wire f_valid;
		wire [8:0] f_data;
		wire [10:0] frame;
		wire tx_roll;
		wire tx_pop;
		wire tx_set;
		wire rx_start;
		wire vote_tick;
		wire vote;
		wire accept;
		wire rx_set;

		assign hit_ctrl = (i_sfr_addr == ctrl_addr(g));
		assign hit_buf = (i_sfr_addr == buf_addr(g));
		assign wr_ctrl = i_sfr_wr && hit_ctrl;
		assign wr_buf = i_sfr_wr && hit_buf;
		assign active = ctrl_r[`UART_MODE_HI];
		assign dbl = aux_r[`UART_DBL0 - g];
		assign use_t2 = (g == 0) && aux_r[`UART_T2SEL]; // R21
		assign ovf = use_t2 ? i_t2_ovf : i_t1_ovf;

		////////////////////////////////////////////////////////////////////
		// Sample tick at sixteen times the bit rate

		always @(posedge i_clk) begin
			if (i_rst) begin
				pre_r <= 2'h0;
				half_r <= 1'b0;
				tick_r <= 1'b0;
			end else begin
				tick_r <= 1'b0;
				if (!ctrl_r[`UART_MODE_LO]) begin
					if (pre_r == 2'h0) begin
						pre_r <= dbl ? `UART_PRE_FAST : `UART_PRE_SLOW; // R03
						tick_r <= 1'b1;
					end else begin
						pre_r <= pre_r - 2'h1;
					end
				end else if (ovf) begin // R16
					if (use_t2 || dbl) begin
						tick_r <= 1'b1; // R20
					end else begin
						half_r <= ~half_r; // R20
						tick_r <= half_r;
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// Transmit path

		pair_buffer #(
			.WIDTH(9)
		) tx_buf (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.i_in_valid(wr_buf),
			.o_in_ready(o_tx_ready[g]),
			.i_in_data({ctrl_r[`UART_TX9], i_sfr_wdata}), // R02
			.o_out_valid(f_valid),
			.i_out_ready(tx_pop),
			.o_out_data(f_data)
		);

		assign frame = {`UART_IDLE_PIN, f_data[8], f_data[7:0], 1'b0}; // R01
		assign tx_roll = tick_r && (txc_r == `UART_SMP_LAST);
		assign tx_pop = tx_roll && active && f_valid && (!tx_busy_r || txi_r == `UART_STOP_IDX); // R04
		assign tx_set = tx_roll && tx_busy_r && (txi_r == `UART_NINTH_IDX); // R06

		always @(posedge i_clk) begin
			if (i_rst) begin
				txc_r <= 4'h0;
				tx_busy_r <= 1'b0;
				txi_r <= 4'h0;
				txs_r <= 11'h7ff;
				txo_r <= `UART_IDLE_PIN;
			end else begin
				if (tick_r) begin
					txc_r <= txc_r + 4'h1;
				end
				if (tx_pop) begin
					tx_busy_r <= 1'b1;
					txi_r <= 4'h0;
					txo_r <= frame[0];
					txs_r <= {1'b1, frame[10:1]};
				end else if (tx_roll && tx_busy_r) begin
					if (txi_r == `UART_STOP_IDX) begin
						tx_busy_r <= 1'b0;
						txo_r <= `UART_IDLE_PIN;
					end else begin
						txi_r <= txi_r + 4'h1;
						txo_r <= txs_r[0]; // R05
						txs_r <= {1'b1, txs_r[10:1]};
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// Receive path

		assign rx_start = tick_r && active && ctrl_r[`UART_RXEN] && !rx_busy_r && rprev_r && !rs2_r; // R07
		assign vote_tick = tick_r && rx_busy_r && (rxc_r == `UART_VOTE_C);
		assign vote = maj3(smp_r[1], smp_r[0], rs2_r); // R10
		assign accept = !ctrl_r[`UART_RXDONE] && (!ctrl_r[`UART_MP] || (vote && rsh_r[8])); // R12 R17
		assign rx_set = vote_tick && (rxi_r == `UART_STOP_IDX) && accept; // R14

		always @(posedge i_clk) begin
			if (i_rst) begin
				rs1_r <= `UART_IDLE_PIN;
				rs2_r <= `UART_IDLE_PIN;
				rprev_r <= `UART_IDLE_PIN;
				rx_busy_r <= 1'b0;
				rxc_r <= 4'h0;
				rxi_r <= 4'h0;
				smp_r <= 2'h3;
				rsh_r <= 9'h000;
			end else begin
				rs1_r <= i_serial_in_pin[g];
				rs2_r <= rs1_r;
				if (tick_r) begin
					rprev_r <= rs2_r; // R08
				end
				if (rx_start) begin
					rx_busy_r <= 1'b1;
					rxc_r <= 4'h0; // R09
					rxi_r <= 4'h0;
				end else if (tick_r && rx_busy_r) begin
					rxc_r <= rxc_r + 4'h1;
					if (rxc_r >= `UART_VOTE_A && rxc_r < `UART_VOTE_C) begin
						smp_r <= {smp_r[0], rs2_r};
					end
					if (rxc_r == `UART_VOTE_C) begin
						rxi_r <= rxi_r + 4'h1;
						if (rxi_r == 4'h0 && vote) begin
							rx_busy_r <= 1'b0; // R11
						end else if (rxi_r == `UART_STOP_IDX) begin
							rx_busy_r <= 1'b0; // R15
						end else if (rxi_r != 4'h0) begin
							rsh_r <= {vote, rsh_r[8:1]}; // R01
						end
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// Control and buffer registers; hardware sets win over writes

		always @* begin
			ctrl_nxt = wr_ctrl ? i_sfr_wdata : ctrl_r;
			if (tx_set) begin
				ctrl_nxt[`UART_TXDONE] = 1'b1;
			end
			if (rx_set) begin
				ctrl_nxt[`UART_RXDONE] = 1'b1; // R13
				ctrl_nxt[`UART_RX9] = rsh_r[8]; // R13
			end
		end

		always @(posedge i_clk) begin
			if (i_rst) begin
				ctrl_r <= `UART_CTRL_RST;
				rbuf_r <= `UART_BUF_RST;
			end else begin
				ctrl_r <= ctrl_nxt;
				if (rx_set) begin
					rbuf_r <= rsh_r[7:0]; // R13
				end
			end
		end

		////////////////////////////////////////////////////////////////////
		// Read select for this port

		always @* begin
			rd_port = 8'h00;
			if (hit_ctrl) begin
				rd_port = ctrl_r;
			end else if (hit_buf) begin
				rd_port = rbuf_r;
			end
		end

		assign port_rd[8*g +: 8] = rd_port;
		assign o_serial_out_pin[g] = txo_r;
		assign o_tx_done_flag[g] = ctrl_r[`UART_TXDONE];
		assign o_rx_done_flag[g] = ctrl_r[`UART_RXDONE];
		assign o_serial_irq[g] = ctrl_r[`UART_TXDONE] | ctrl_r[`UART_RXDONE]; // R17
	end
endgenerate

endmodule

// File: bench/uart_props.sv
// Port checker for the nine-bit serial ports
`timescale 1ns/1ps
`include "uart_map.vh"
module uart_props #(
	parameter PORTS = 2
) (
	input wire i_clk,
	input wire i_rst,
	input wire [7:0] i_sfr_addr,
	input wire i_sfr_wr,
	input wire i_sfr_rd,
	input wire [7:0] o_sfr_rdata,
	input wire o_t2_inc,
	input wire [PORTS-1:0] o_serial_out_pin,
	input wire [PORTS-1:0] o_tx_ready,
	input wire [PORTS-1:0] o_tx_done_flag,
	input wire [PORTS-1:0] o_rx_done_flag,
	input wire [PORTS-1:0] o_serial_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic ctrl0_wr_r;
	always @(posedge i_clk) begin
		ctrl0_wr_r <= i_sfr_wr && (i_sfr_addr == `UART_CTRL0_ADDR);
	end
	////////////////////////////////////////////////////////////
	chk_irq_flags: assert property (o_serial_irq == (o_tx_done_flag | o_rx_done_flag))
		else $error("irq differs from flags");
	chk_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
		else $error("read data moved without read");
	chk_reset_idle: assert property ($fell(i_rst) |-> o_serial_out_pin == '1 && o_tx_ready == '1 && !o_t2_inc)
		else $error("outputs not idle after reset");
	chk_stop_high: assert property ($rose(o_tx_done_flag[0]) |-> o_serial_out_pin[0] [*8])
		else $error("stop bit not driven with done flag");
	chk_start_low: assert property ($fell(o_serial_out_pin[0]) |-> !o_serial_out_pin[0] [*8])
		else $error("low bit too short");
	chk_high_bit: assert property ($rose(o_serial_out_pin[0]) |-> o_serial_out_pin[0] [*8])
		else $error("high bit too short");
	chk_t2_rate: assert property (o_t2_inc |=> !o_t2_inc)
		else $error("timer increment not at half rate");
	chk_rx_keep: assert property ($fell(o_rx_done_flag[0]) |-> ctrl0_wr_r)
		else $error("receive flag cleared without write");
	chk_tx_keep: assert property ($fell(o_tx_done_flag[0]) |-> ctrl0_wr_r)
		else $error("transmit flag cleared without write");
endmodule
bind nine_bit_uart_multiproc uart_props #(.PORTS(PORTS)) props_i (.i_clk(i_clk), .i_rst(i_rst),
	.i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
	.o_t2_inc(o_t2_inc), .o_serial_out_pin(o_serial_out_pin), .o_tx_ready(o_tx_ready),
	.o_tx_done_flag(o_tx_done_flag), .o_rx_done_flag(o_rx_done_flag), .o_serial_irq(o_serial_irq));

// File: bench/remote_uart.sv
// Remote serial partner that sends and captures frames
`timescale 1ns/1ps
module remote_uart (
	input wire i_clk,
	input wire i_line,
	output logic o_line
);
	initial o_line = 1'b1;
	task send(input logic [8:0] w, input int bt);
		logic [10:0] f;
		f = {1'b1, w, 1'b0};
		for (int i = 0; i < 11; i++) begin
			o_line = f[i];
			repeat (bt) @(negedge i_clk);
		end
	endtask
	task recv(input int bt, output logic [10:0] f, output bit ok);
		int n;
		n = 0;
		while (i_line !== 1'b0 && n < 20000) begin
			@(negedge i_clk);
			n++;
		end
		ok = (n < 20000);
		repeat (bt / 2) @(negedge i_clk);
		for (int i = 0; i < 11; i++) begin
			f[i] = i_line;
			if (i < 10) repeat (bt) @(negedge i_clk);
		end
	endtask
	task glitch;
		o_line = 1'b0;
		repeat (4) @(negedge i_clk);
		o_line = 1'b1;
	endtask
endmodule

// File: bench/testbench.sv
// Register-level bench for the nine-bit serial ports
`timescale 1ns/1ps
module testbench;
	logic i_clk = 1'b0, i_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_t1_ovf = 1'b0, i_t2_ovf = 1'b0;
	logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
	logic [7:0] regs [4] = '{8'h98, 8'hc0, 8'h87, 8'h55};
	wire [7:0] o_sfr_rdata;
	wire [1:0] sout, tx_rdy, txd, rxd, irq;
	wire t2_inc, far_line;
	int failures = 0, total_checks = 0, n;
	logic [10:0] f;
	bit ok;
	logic [3:0] acc;
	nine_bit_uart_multiproc uut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
		.i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_t1_ovf(i_t1_ovf),
		.i_t2_ovf(i_t2_ovf), .o_t2_inc(t2_inc), .i_serial_in_pin({sout[1], far_line}), .o_serial_out_pin(sout),
		.o_tx_ready(tx_rdy), .o_tx_done_flag(txd), .o_rx_done_flag(rxd), .o_serial_irq(irq));
	remote_uart far (.i_clk(i_clk), .i_line(sout[0]), .o_line(far_line));
	always #20 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////
	task check(input string name, input logic [10:0] got, input logic [10:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task print_verdict;
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(negedge i_clk);
		i_sfr_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_clk);
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		@(negedge i_clk);
		i_sfr_rd = 1'b0;
		check("register", o_sfr_rdata, exp);
	endtask
	task wait_rx(input int p);
		int k;
		k = 0;
		while (rxd[p] !== 1'b1 && k < 4000) begin
			@(negedge i_clk);
			k++;
		end
		if (k == 4000) begin
			failures++;
			print_verdict();
		end
	endtask
	task get_frame(input int bt);
		far.recv(bt, f, ok);
		if (!ok) begin
			failures++;
			print_verdict();
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00);
		wr(8'h87, 8'h80);
		wr(8'h98, 8'h98);
		wr(8'h99, 8'ha5);
		get_frame(32);
		check("tx frame", f, {2'b11, 8'ha5, 1'b0});
		check("tx done", txd[0], 1);
		far.send({1'b0, 8'h3c}, 32);
		wait_rx(0);
		rd(8'h99, 8'h3c);
		rd(8'h98, 8'h9b);
		far.send({1'b1, 8'h5a}, 32);
		repeat (8) @(negedge i_clk);
		rd(8'h99, 8'h3c);
		rd(8'h98, 8'h9b);
		wr(8'h98, 8'h98);
		far.glitch();
		repeat (400) @(negedge i_clk);
		check("glitch", rxd[0], 0);
		n = 0;
		for (int i = 0; i < 4; i++) begin
			@(negedge i_clk);
			i_sfr_addr = 8'h99;
			i_sfr_wdata = 8'h10 + i[7:0];
			i_sfr_wr = 1'b1;
			acc[i] = (tx_rdy[0] === 1'b1);
			if (acc[i]) begin
				n++;
			end
			@(negedge i_clk);
			i_sfr_wr = 1'b0;
		end
		check("fill", n >= 2 && n <= 3, 1);
		for (int i = 0; i < 4; i++) begin
			if (acc[i]) begin
				get_frame(32);
				check("queued", f, {2'b11, 8'h10 + i[7:0], 1'b0});
			end
		end
		repeat (40) @(negedge i_clk);
		check("dropped", {sout[0], tx_rdy[0]}, 2'b11);
		wr(8'h98, 8'hb0);
		far.send({1'b0, 8'h77}, 32);
		repeat (8) @(negedge i_clk);
		check("data byte", irq[0], 0);
		far.send({1'b1, 8'h21}, 32);
		wait_rx(0);
		rd(8'h99, 8'h21);
		rd(8'h98, 8'hb5);
		wr(8'h98, 8'h90);
		far.send({1'b0, 8'h44}, 32);
		wait_rx(0);
		rd(8'h99, 8'h44);
		wr(8'hc0, 8'hd0);
		i_t1_ovf = 1'b1;
		wr(8'hc1, 8'h69);
		wait_rx(1);
		rd(8'hc1, 8'h69);
		rd(8'hc0, 8'hd3);
		check("irq1", irq[1], 1);
		wr(8'hc0, 8'h90);
		wr(8'hc1, 8'h01);
		n = 0;
		while (sout[1] !== 1'b0 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		n = 0;
		while (sout[1] === 1'b0 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		check("slow bit", n, 64);
		wait_rx(1);
		rd(8'hc1, 8'h01);
		i_t2_ovf = 1'b1;
		wr(8'h87, 8'ha0);
		wr(8'h98, 8'hd0);
		wr(8'h99, 8'hc3);
		get_frame(16);
		check("t2 frame", f, {2'b10, 8'hc3, 1'b0});
		print_verdict();
	end
endmodule
